// >>> logic/p3l_port3_output_latch.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Port 3 output latch with an APB register slave.
// ==========================================================================
module p3l_port3_output_latch
  import p3l_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port3_pin_i,
  output logic [7:0] port3_pin_o,
  output logic [7:0] port3_pin_oe_n
);

  // ========================================================================
  // Bus slave state.
  // ========================================================================
  typedef struct packed {
    p3l_phase_t phase;    // Idle or answering an access.
    logic pready;         // Access completes while this is high.
    logic pslverr;        // Error answer for the current access.
    logic [31:0] prdata;  // Read data, captured in the setup cycle.
  } p3l_bus_t;

  p3l_bus_t s_r;
  p3l_bus_t s_nxt;

  // Pin state gathered from the cells.
  logic [7:0] latch_bits; // Written output levels.
  logic [7:0] cfg_bits;   // Output configuration bits.

  // Decoded request.
  logic setup;       // Setup cycle of a transfer.
  logic hit_data;    // Address selects the pin data register.
  logic hit_cfg;     // Address selects the configuration register.
  logic hit_latch;   // Address selects the latch readback.
  logic mapped;      // Address selects any register.
  logic bad;         // Access gets an error answer.
  logic done;        // Access completes at this edge.
  logic wr_ok;       // A write takes effect at this edge.
  logic data_we;     // Write strobe for the pin latches.
  logic cfg_we;      // Write strobe for the configuration bits.

  // Address decode. The address is stable from setup to completion.
  always_comb begin
    setup = psel & ~penable;
    hit_data = (paddr == P3L_DATA_OFS);
    hit_cfg = (paddr == P3L_CFG_OFS);
    hit_latch = (paddr == P3L_LATCH_OFS);
    mapped = hit_data | hit_cfg | hit_latch;
    // The latch readback has no write path, so a write to it is refused.
    bad = ~mapped | (pwrite & hit_latch);
  end

  // Write strobes. A write counts only at the completing edge, only when
  // it was not refused and only when the low byte lane is enabled; the
  // upper lanes hold nothing.
  always_comb begin
    done = (s_r.phase == P3L_ANSWER) & psel & penable & s_r.pready;
    wr_ok = done & pwrite & ~s_r.pslverr & pstrb[0];
    data_we = wr_ok & hit_data;
    cfg_we = wr_ok & hit_cfg;
  end

  // ========================================================================
  // Bus answer sequencing.
  // ========================================================================
  // Read data is taken in the setup cycle so that pready can be a flop and
  // still answer in the first access cycle. The trade-off is that a pin
  // read shows the level one cycle before the completing edge.
  always_comb begin
    s_nxt = s_r;
    s_nxt.pready = 1'b0;
    unique case (s_r.phase)
      P3L_IDLE: begin
        if (setup) begin
          s_nxt.phase = P3L_ANSWER;
          s_nxt.pready = 1'b1;
          s_nxt.pslverr = bad;
          s_nxt.prdata = 32'h0000_0000;
          if (!pwrite) begin
            if (hit_data) begin
              // The sensed pin level, not the latch, is returned.
              s_nxt.prdata[P3L_FIELD_MSB:P3L_FIELD_LSB] = port3_pin_i;
            end else if (hit_cfg) begin
              s_nxt.prdata[P3L_FIELD_MSB:P3L_FIELD_LSB] = cfg_bits;
            end else if (hit_latch) begin
              s_nxt.prdata[P3L_FIELD_MSB:P3L_FIELD_LSB] = latch_bits;
            end else begin
              s_nxt.prdata = 32'h0000_0000;
            end
          end
        end else begin
          s_nxt.pslverr = 1'b0;
        end
      end
      P3L_ANSWER: begin
        if (done || !psel) begin
          // Transfer over, or abandoned by the master.
          s_nxt.phase = P3L_IDLE;
          s_nxt.pslverr = 1'b0;
        end else begin
          s_nxt.pready = s_r.pready;
        end
      end
    endcase
  end

  // Bus registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r.phase <= P3L_IDLE;
      s_r.pready <= 1'b0;
      s_r.pslverr <= 1'b0;
      s_r.prdata <= 32'h0000_0000;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;

  // ========================================================================
  // Pin cells.
  // ========================================================================
  // Each cell holds its own latch and configuration bit and registers its
  // driver enable, so the pin outputs come straight from flops.
  for (genvar i = 0; i < P3L_PINS; i++) begin : g_pin
    p3l_pin_cell #(
      .IDX(i)
    ) u_cell (
      .pclk(pclk),
      .presetn(presetn),
      .data_we(data_we),
      .cfg_we(cfg_we),
      .wbit(pwdata[i]),
      .latch(latch_bits[i]),
      .cfg(cfg_bits[i]),
      .pin_o(port3_pin_o[i]),
      .pin_oe_n(port3_pin_oe_n[i])
    );
  end

  // ========================================================================
  // Checks.
  // ========================================================================
  property p_read_pins;
    @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && hit_data && s_r.phase == P3L_IDLE
      |=> prdata == {24'h00_0000, $past(port3_pin_i)} && pready;
  endproperty
  a_read_pins: assert property (p_read_pins)
    else $error("Data read did not return the sensed pin levels.");

  property p_reset_high;
    @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> port3_pin_o == P3L_DATA_RST;
  endproperty
  a_reset_high: assert property (p_reset_high)
    else $error("Pin latches not all high after reset.");

  property p_write_latch;
    @(posedge pclk) disable iff (!presetn)
      data_we |=> port3_pin_o == $past(pwdata[7:0])
      && port3_pin_oe_n == ($past(pwdata[7:0]) & ~cfg_bits);
  endproperty
  a_write_latch: assert property (p_write_latch)
    else $error("Pin drive does not follow the written data.");

  property p_error_answer;
    @(posedge pclk) disable iff (!presetn)
      setup && !mapped && s_r.phase == P3L_IDLE |=> pready && pslverr;
  endproperty
  a_error_answer: assert property (p_error_answer)
    else $error("Unmapped access was not answered with an error.");

  property p_one_cycle_ready;
    @(posedge pclk) disable iff (!presetn)
      done |=> !pready;
  endproperty
  a_one_cycle_ready: assert property (p_one_cycle_ready)
    else $error("Ready stayed high past the completing edge.");

  // A write to the read-only latch readback is refused. Software that
  // mistakes it for the data register then learns of it at once.
  property p_refuse_latch_write;
    @(posedge pclk) disable iff (!presetn)
      setup && pwrite && hit_latch && s_r.phase == P3L_IDLE
      |=> pready && pslverr;
  endproperty
  a_refuse_latch_write: assert property (p_refuse_latch_write)
    else $error("Write to the latch readback was not refused.");

  // Every accepted setup is answered in the very next cycle.
  property p_zero_wait;
    @(posedge pclk) disable iff (!presetn)
      setup && s_r.phase == P3L_IDLE |=> pready;
  endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("Setup was not answered in the next cycle.");

  // A write with the low byte lane off leaves every pin as it was.
  // The next cycle cannot complete a transfer, so nothing else can move.
  property p_lane_off_kept;
    @(posedge pclk) disable iff (!presetn)
      done && pwrite && !pstrb[0] |=> $stable(port3_pin_o)
      && $stable(port3_pin_oe_n);
  endproperty
  a_lane_off_kept: assert property (p_lane_off_kept)
    else $error("Masked write changed the pin drive.");

endmodule
`default_nettype wire

// >>> shared/p3l_pkg.sv
`default_nettype none
// ==========================================================================
// Shared constants for the port 3 output latch block.
// ==========================================================================
package p3l_pkg;

  // Number of pins on the port.
  localparam int P3L_PINS = 8;

  // Byte offsets of the registers on the APB bus.
  localparam logic [7:0] P3L_DATA_OFS = 8'hb0;  // Pin data register.
  localparam logic [7:0] P3L_CFG_OFS = 8'hb4;   // Output configuration.
  localparam logic [7:0] P3L_LATCH_OFS = 8'hb8; // Latch readback, read-only.

  // Reset values.
  localparam logic [7:0] P3L_DATA_RST = 8'hff;  // All latches high.
  localparam logic [7:0] P3L_CFG_RST = 8'h00;   // All pins open-drain.

  // Field layout: the eight pin bits sit in the low byte of the word.
  localparam int P3L_FIELD_LSB = 0;
  localparam int P3L_FIELD_MSB = 7;

  // Bus answer phase of the register slave.
  typedef enum logic {
    P3L_IDLE,
    P3L_ANSWER
  } p3l_phase_t;

endpackage
`default_nettype wire

// >>> logic/p3l_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// One port pin: its output latch, its configuration bit and its driver.
// ==========================================================================
module p3l_pin_cell
  import p3l_pkg::*;
#(
  parameter int IDX = 0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic data_we,
  input wire logic cfg_we,
  input wire logic wbit,
  output logic latch,
  output logic cfg,
  output logic pin_o,
  output logic pin_oe_n
);

  // ========================================================================
  // State of the pin.
  // ========================================================================
  typedef struct packed {
    logic latch; // Written output level.
    logic cfg;   // One selects push-pull, zero open-drain.
    logic oe_n;  // Low while the pin is driven.
  } p3l_cell_t;

  p3l_cell_t s_r;
  p3l_cell_t s_nxt;

  // Next state. The enable is worked out from the next latch and config
  // values so that the driver changes in the same edge as the latch and
  // never shows a stale mix of the two.
  always_comb begin
    s_nxt = s_r;
    if (data_we) begin
      s_nxt.latch = wbit;
    end
    if (cfg_we) begin
      s_nxt.cfg = wbit;
    end
    // A zero is always driven low; a one is driven only in push-pull.
    s_nxt.oe_n = s_nxt.latch & ~s_nxt.cfg;
  end

  // Registers. Reset leaves the latch high and the pin floating.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r.latch <= P3L_DATA_RST[IDX];
      s_r.cfg <= P3L_CFG_RST[IDX];
      s_r.oe_n <= P3L_DATA_RST[IDX] & ~P3L_CFG_RST[IDX];
    end else begin
      s_r <= s_nxt;
    end
  end

  assign latch = s_r.latch;
  assign cfg = s_r.cfg;
  assign pin_o = s_r.latch;
  assign pin_oe_n = s_r.oe_n;

  // ========================================================================
  // Checks on the driver.
  // ========================================================================
  property p_drive_low;
    @(posedge pclk) disable iff (!presetn)
      data_we && !wbit |=> !pin_o && !pin_oe_n;
  endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("Written zero did not drive the pin low.");

  property p_float_high;
    @(posedge pclk) disable iff (!presetn)
      pin_o && !cfg |-> pin_oe_n;
  endproperty
  a_float_high: assert property (p_float_high)
    else $error("Open-drain high pin was driven.");

  property p_push_high;
    @(posedge pclk) disable iff (!presetn)
      data_we && wbit && cfg && !cfg_we |=> pin_o && !pin_oe_n;
  endproperty
  a_push_high: assert property (p_push_high)
    else $error("Push-pull high pin was not driven.");

endmodule
`default_nettype wire

// >>> dv/p3l_port3_output_latch_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Self-checking bench for the port 3 latch, driven over APB.
// ==========================================================================
module p3l_port3_output_latch_tb;
  import p3l_pkg::*;
  logic pclk, presetn, psel, penable, pwrite; // Bus control.
  logic [7:0] paddr; // Byte address.
  logic [31:0] pwdata, prdata; // Bus data.
  logic [3:0] pstrb; // Byte lanes.
  logic pready, pslverr; // Slave answer.
  logic [7:0] pin_i, pin_o, pin_oe_n; // Pin side.
  logic [7:0] d, c, p; // Written data, config and sensed pin pattern.
  int err_count, n_tests, i; // Counters and loop index.
  integer seed; // Seed of the repeatable random stream.
  p3l_port3_output_latch u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port3_pin_i(pin_i), .port3_pin_o(pin_o), .port3_pin_oe_n(pin_oe_n));
  // A pin floats only when its latch is one and it is open-drain.
  function automatic logic [7:0] exp_oe_n(input logic [7:0] l, f);
    return l & ~f;
  endfunction
  // ========================================================================
  // Clock, checks and bus tasks.
  // ========================================================================
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Case equality keeps an unknown from passing as a match.
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] wd, input logic [3:0] s, output logic [31:0] rd,
      output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Only pready or the watchdog ends a wait; the answer latency is then compared
    // with the single access cycle that the slave promises.
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("ready wait", 32'h1, n);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v,
      input logic [3:0] s, input logic ee);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, {24'h0, v}, s, rd, er);
    chk("write error", {31'h0, ee}, {31'h0, er});
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
      input logic [31:0] e, input logic ee);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0, 4'h0, rd, er);
    chk("read error", {31'h0, ee}, {31'h0, er});
    chk(nm, e, rd);
  endtask
  task automatic pins(input logic [7:0] l, f);
    chk("pin level", {24'h0, l}, {24'h0, pin_o});
    chk("pin enable", {24'h0, exp_oe_n(l, f)}, {24'h0, pin_oe_n});
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // The whole run needs under a thousand cycles; this bound cuts a hang.
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    close_out;
  end
  // ========================================================================
  // Main sequence.
  // ========================================================================
  initial begin
    seed = 32'h1e2c64c6;
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    pin_i = 8'h5a;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    pins(8'hff, 8'h00);
    rdc("latch", P3L_LATCH_OFS, 32'hff, 1'b0);
    rdc("config", P3L_CFG_OFS, 32'h0, 1'b0);
    $display("reset values done");
    // The first three passes are corner patterns, the rest are random.
    for (i = 0; i < 40; i++) begin
      d = 8'($random(seed));
      c = 8'($random(seed));
      if (i == 0) {d, c} = 16'h00ff;
      if (i == 1) {d, c} = 16'hff00;
      if (i == 2) {d, c} = 16'hffff;
      wr(P3L_CFG_OFS, c, 4'h1, 1'b0);
      wr(P3L_DATA_OFS, d, 4'hf, 1'b0);
      pins(d, c);
      // Pins differ from the latch in about half the bits, so a latch readback would show.
      p = 8'(~d ^ $random(seed));
      @(posedge pclk);
      pin_i <= p;
      rdc("sensed", P3L_DATA_OFS, {24'h0, p}, 1'b0);
      rdc("latch", P3L_LATCH_OFS, {24'h0, d}, 1'b0);
      rdc("config", P3L_CFG_OFS, {24'h0, c}, 1'b0);
    end
    $display("random writes done");
    // Refused and ignored accesses leave the pins alone.
    wr(P3L_LATCH_OFS, ~d, 4'hf, 1'b1);
    wr(8'hbc, ~d, 4'hf, 1'b1);
    wr(P3L_DATA_OFS, ~d, 4'he, 1'b0);
    rdc("unmapped", 8'h00, 32'h0, 1'b1);
    pins(d, c);
    $display("refusals done");
    // A reset in mid-run returns every latch to one.
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    pins(8'hff, 8'h00);
    rdc("latch", P3L_LATCH_OFS, 32'hff, 1'b0);
    rdc("config", P3L_CFG_OFS, 32'h0, 1'b0);
    $display("mid-run reset done");
    close_out;
  end
endmodule
`default_nettype wire
